// *** rtl/bpc_map.svh ***
// Buffer processor core constants
`ifndef BPC_MAP_SVH
`define BPC_MAP_SVH

// Operand field codes (source or destination)
`define BPC_OPD_STAT1      3'h0
`define BPC_OPD_SCRATCH    3'h1
`define BPC_OPD_MSGBUF     3'h2
`define BPC_OPD_CONST      3'h3
`define BPC_OPD_ACC        3'h4
`define BPC_OPD_IO         3'h5
`define BPC_OPD_STAT2      3'h6
`define BPC_OPD_COUNT      3'h7

// Message address codes
`define BPC_MADDR_CPU      2'h0
`define BPC_MADDR_PROG     2'h1
`define BPC_MADDR_JUMP     2'h2
`define BPC_MADDR_CONST    2'h3
`define BPC_MSG_WORDS      336

// First status register bit positions
`define BPC_S1_CHAR_WAIT   0
`define BPC_S1_OUT_READY   1
`define BPC_S1_MSG_AVAIL   2
`define BPC_S1_CPU_ACCESS  3
`define BPC_S1_INT_ERR     4
`define BPC_S1_IF_ERR      5

// Second status register bit positions
`define BPC_S2_MT_BUSY     0
`define BPC_S2_ACK_READY   3
`define BPC_S2_ACK_LSB     4

// Word mode modifiers
`define BPC_MODE_WR_WORD   4'h0
`define BPC_MODE_RD_WORD   4'h1

// Word timing: eight data bits plus the spacer bit
`define BPC_WORD_BITS      9
`define BPC_SPACER_BIT     4'h8

// Reset values
`define BPC_RST_BYTE       8'h00
`define BPC_RST_WORD       9'h100

`endif

// *** rtl/bpc_pkg.sv ***
// Types shared by the buffer processor core
package bpc_pkg;

    // One stored word: odd parity bit over eight data bits
    typedef struct packed {
        logic       par;
        logic [7:0] data;
    } bpc_word_s;

    typedef enum logic [3:0] {
        OP_NOP     = 4'b0000,
        OP_OR      = 4'b0001,
        OP_AND     = 4'b0010,
        OP_ADD     = 4'b0011,
        OP_SUB     = 4'b0100,
        OP_CMP     = 4'b0101,
        OP_LOOKUP  = 4'b0110,
        OP_TO_MT   = 4'b0111,
        OP_FROM_MT = 4'b1000,
        OP_MARKER  = 4'b1001,
        OP_WORD_MT = 4'b1010,
        OP_STORE   = 4'b1011,
        OP_HALT    = 4'b1100,
        OP_INPUT   = 4'b1101,
        OP_OUTPUT  = 4'b1110
    } bpc_op_e;

    typedef enum logic [2:0] {
        MT_IDLE    = 3'b000,
        MT_SEEK_WR = 3'b001,
        MT_PUT_WR  = 3'b010,
        MT_SEEK_RD = 3'b011,
        MT_GET_RD  = 3'b100,
        MT_COPY    = 3'b101
    } bpc_mt_state_e;

endpackage

// *** rtl/bpc_core.sv ***
// Buffer processor core logic
//
// Functional notes
// - Accumulator checks parity on loads, adds odd parity on stores; flags exempt.
// - Counter register counts compare skips and takes the lookup result word.
// - Two instruction ranks; lower copied to upper at spacer bit time.
// - Both flag registers are 8 bits, no parity, reached only via accumulator.
// - Message buffer holds nine bits; only eight data bits go to the track.
// - Message read finds marker, loads next word, moves marker one word on.
// - Message write finds marker, writes next word position, moves marker on.
// - Instruction word: bit 9 odd parity, command high, bits 1-4 operand or mode.
// - Operand codes 0-7: flags1, scratch, msg buffer, constant, acc, io, flags2, counter.
// - Message addresses 0-3: processor, program, jump, constant; 336 words each.
// - Words copied from message track to codes 1-3 get generated parity.
// - Flags1 bits 1-6 and flags2 bits 1 and 4-8 carry the listed status meanings.
// - Flags read by masked product, written by masked store leaving others alone.
// - Input waiting flag sets on arrival, stays set until program clears it.
// - Output ready set only by program, cleared when output holder empties.
// - Message available set by program, cleared by processor on transfer done.
// - Internal error sets on instruction, accumulator load or processor parity error.
// - Interface error sets on input holder parity error; program may set it.
// - Message track busy is set and cleared by hardware only.
// - Fifteen opcodes; 0-5 are nop, or, and, add, subtract, compare.
// - Logical product ands constant word with operand into accumulator.
// - Add and subtract drop overflow; subtract ignores the constant mask.
// - True compare loads counter from jump track, suppresses execution to zero.
`include "bpc_map.svh"
`timescale 1ns/1ns
`default_nettype none

module bpc_core #(
    parameter int MSG_WORDS = `BPC_MSG_WORDS
) (
    input  wire logic              clk,
    input  wire logic              nrst,
    // Disc track words
    input  wire bpc_pkg::bpc_word_s progWord,
    input  wire bpc_pkg::bpc_word_s constWord,
    input  wire bpc_pkg::bpc_word_s scratchWord,
    input  wire logic [7:0]        jumpWord,
    input  wire logic [8:0]        msgTrackIn,
    input  wire logic              originPulse,
    // Processor side
    input  wire bpc_pkg::bpc_word_s cpuWord,
    input  wire logic              cpuWordValid,
    input  wire logic              cpuAccess,
    input  wire logic              cpuXferDone,
    // Device side holders
    input  wire bpc_pkg::bpc_word_s inHolder,
    input  wire logic              charArrive,
    input  wire logic              outHolderEmpty,
    // Outputs
    output logic                   spacerTime,
    output bpc_pkg::bpc_word_s     scratchWrData,
    output logic                   scratchWrEn,
    output logic [8:0]             msgTrackOut,
    output logic                   msgTrackWrEn,
    output bpc_pkg::bpc_word_s     copyData,
    output logic [1:0]             copyDest,
    output logic                   copyValid,
    output bpc_pkg::bpc_word_s     ioData,
    output logic [7:0]             statusOne,
    output logic [7:0]             statusTwo,
    output logic [7:0]             accOut,
    output logic                   halted
);

    // ----------
    // Input synchronisers
    // ----------
    localparam int NSYNC = 4;
    logic [NSYNC-1:0] asyncIn;
    logic [NSYNC-1:0] syncA_q;
    logic [NSYNC-1:0] syncB_q;
    logic [NSYNC-1:0] syncC_q;
    logic [NSYNC-1:0] stable_q;
    logic [NSYNC-1:0] stablePrev_q;

    assign asyncIn = {cpuXferDone, outHolderEmpty, charArrive, cpuAccess};

    // Updates once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            syncA_q      <= '0;
            syncB_q      <= '0;
            syncC_q      <= '0;
            stable_q     <= '0;
            stablePrev_q <= '0;
        end else begin
            syncA_q      <= asyncIn;
            syncB_q      <= syncA_q;
            syncC_q      <= syncB_q;
            stablePrev_q <= stable_q;
            for (int i = 0; i < NSYNC; i++) begin
                if (syncB_q[i] == syncC_q[i]) begin
                    stable_q[i] <= syncC_q[i];
                end
            end
        end
    end

    logic accessLvl;
    logic charRise;
    logic emptyRise;
    logic doneRise;
    assign accessLvl = stable_q[0];
    assign charRise  = stable_q[1] & ~stablePrev_q[1];
    assign emptyRise = stable_q[2] & ~stablePrev_q[2];
    assign doneRise  = stable_q[3] & ~stablePrev_q[3];

    // ----------
    // Bit timing
    // ----------
    logic [3:0] bitCnt_q;
    logic       spacer;
    assign spacer = (bitCnt_q == `BPC_SPACER_BIT);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            bitCnt_q   <= 4'h0;
            spacerTime <= 1'b0;
        end else begin
            bitCnt_q   <= spacer ? 4'h0 : bitCnt_q + 4'h1;
            spacerTime <= (bitCnt_q == `BPC_SPACER_BIT - 4'h1);
        end
    end

    // ----------
    // Registers
    // ----------
    bpc_pkg::bpc_word_s upper_q;
    bpc_pkg::bpc_word_s lower_q;
    bpc_pkg::bpc_word_s msgBuf_q;
    bpc_pkg::bpc_word_s ioReg_q;
    logic [7:0]         acc_q;
    logic [7:0]         count_q;
    logic [7:0]         stat1_q;
    logic [7:0]         stat2_q;
    logic               halt_q;

    bpc_pkg::bpc_op_e   op;
    logic [3:0]         mode;
    logic [2:0]         opd;
    assign op   = bpc_pkg::bpc_op_e'(upper_q.data[7:4]);
    assign mode = upper_q.data[3:0];
    assign opd  = upper_q.data[2:0];

    // Countdown stops execution, not fetch
    logic execNow;
    assign execNow = spacer && (count_q == 8'h00) && !halt_q;

    // Flags carry no parity
    bpc_pkg::bpc_word_s operand;
    logic               opdHasPar;
    always_comb begin
        opdHasPar = 1'b1;
        case (opd)
            `BPC_OPD_STAT1:   begin
                operand   = {1'b0, stat1_q};
                opdHasPar = 1'b0;
            end
            `BPC_OPD_SCRATCH: operand = scratchWord;
            `BPC_OPD_MSGBUF:  operand = msgBuf_q;
            `BPC_OPD_CONST:   operand = constWord;
            `BPC_OPD_ACC:     operand = {~^acc_q, acc_q};
            `BPC_OPD_IO:      operand = ioReg_q;
            `BPC_OPD_STAT2:   begin
                operand   = {1'b0, stat2_q};
                opdHasPar = 1'b0;
            end
            default:          operand = {~^count_q, count_q};
        endcase
    end

    logic opdParErr;
    logic instrParErr;
    logic loadsAcc;
    assign opdParErr   = opdHasPar && !(^operand);
    assign instrParErr = spacer && !(^progWord);
    assign loadsAcc    = (op == bpc_pkg::OP_OR) || (op == bpc_pkg::OP_AND) ||
                         (op == bpc_pkg::OP_ADD) || (op == bpc_pkg::OP_SUB);

    logic       isStore;
    logic [7:0] storeVal;
    logic [7:0] storeBase;
    assign isStore   = execNow && (op == bpc_pkg::OP_STORE);
    assign storeBase = operand.data;
    // Bits outside the mask stay
    assign storeVal  = (storeBase & ~constWord.data) | (acc_q & constWord.data);

    // ----------
    // Instruction ranks and accumulator
    // ----------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            upper_q <= `BPC_RST_WORD;
            lower_q <= `BPC_RST_WORD;
        end else if (spacer) begin
            upper_q <= lower_q;
            lower_q <= progWord;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            acc_q <= `BPC_RST_BYTE;
        end else if (execNow) begin
            case (op)
                bpc_pkg::OP_OR:  acc_q <= acc_q | operand.data;
                bpc_pkg::OP_AND: acc_q <= constWord.data & operand.data;
                bpc_pkg::OP_ADD: acc_q <= acc_q + operand.data;
                bpc_pkg::OP_SUB: acc_q <= acc_q - operand.data;
                bpc_pkg::OP_STORE: begin
                    if (opd == `BPC_OPD_ACC) begin
                        acc_q <= storeVal;
                    end
                end
                default: acc_q <= acc_q;
            endcase
        end
    end

    // No restart path
    always_ff @(posedge clk) begin
        if (!nrst) begin
            halt_q <= 1'b0;
        end else if (execNow && op == bpc_pkg::OP_HALT && mode == 4'h0) begin
            halt_q <= 1'b1;
        end
    end

    // ----------
    // Counter register
    // ----------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            count_q <= `BPC_RST_BYTE;
        end else if (spacer && count_q != 8'h00) begin
            count_q <= count_q - 8'h01;
        end else if (execNow) begin
            if (op == bpc_pkg::OP_CMP && operand.data == acc_q) begin
                count_q <= jumpWord;
            end else if (op == bpc_pkg::OP_LOOKUP && operand.data == acc_q) begin
                count_q <= jumpWord;
            end else if (isStore && opd == `BPC_OPD_COUNT) begin
                count_q <= storeVal;
            end
        end
    end

    // ----------
    // Scratch track and I/O register
    // ----------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            scratchWrData <= `BPC_RST_WORD;
            scratchWrEn   <= 1'b0;
        end else begin
            scratchWrEn <= isStore && (opd == `BPC_OPD_SCRATCH);
            if (isStore && opd == `BPC_OPD_SCRATCH) begin
                scratchWrData <= {~^storeVal, storeVal};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ioReg_q <= `BPC_RST_WORD;
        end else if (charRise) begin
            ioReg_q <= inHolder;
        end else if (isStore && opd == `BPC_OPD_IO) begin
            ioReg_q <= {~^storeVal, storeVal};
        end
    end

    // ----------
    // Status flags; hardware set wins over a program clear
    // ----------
    logic st1Wr;
    logic st2Wr;
    logic cpuParErr;
    assign st1Wr     = isStore && (opd == `BPC_OPD_STAT1);
    assign st2Wr     = isStore && (opd == `BPC_OPD_STAT2);
    assign cpuParErr = cpuWordValid && !(^cpuWord);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat1_q <= `BPC_RST_BYTE;
        end else begin
            if (st1Wr) begin
                stat1_q <= storeVal;
            end
            // Live line, not settable
            stat1_q[`BPC_S1_CPU_ACCESS] <= accessLvl;
            if (charRise) begin
                stat1_q[`BPC_S1_CHAR_WAIT] <= 1'b1;
            end
            if (emptyRise) begin
                stat1_q[`BPC_S1_OUT_READY] <= 1'b0;
            end
            if (doneRise) begin
                stat1_q[`BPC_S1_MSG_AVAIL] <= 1'b0;
            end
            if (instrParErr || cpuParErr || (execNow && loadsAcc && opdParErr)) begin
                stat1_q[`BPC_S1_INT_ERR] <= 1'b1;
            end
            if (charRise && !(^inHolder)) begin
                stat1_q[`BPC_S1_IF_ERR] <= 1'b1;
            end
        end
    end

    bpc_pkg::bpc_mt_state_e mtState_q;
    logic                   mtBusy;
    assign mtBusy = (mtState_q != bpc_pkg::MT_IDLE);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            stat2_q <= `BPC_RST_BYTE;
        end else begin
            if (st2Wr) begin
                stat2_q <= storeVal;
            end
            stat2_q[`BPC_S2_MT_BUSY] <= mtBusy;
        end
    end

    // ----------
    // Message buffer and message track
    // ----------
    logic startWr;
    logic startRd;
    logic startCopy;
    assign startWr   = execNow && op == bpc_pkg::OP_WORD_MT && mode == `BPC_MODE_WR_WORD;
    assign startRd   = execNow && op == bpc_pkg::OP_WORD_MT && mode == `BPC_MODE_RD_WORD;
    assign startCopy = execNow && op == bpc_pkg::OP_FROM_MT;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            mtState_q <= bpc_pkg::MT_IDLE;
        end else if (spacer) begin
            case (mtState_q)
                bpc_pkg::MT_IDLE: begin
                    if (startWr) begin
                        mtState_q <= bpc_pkg::MT_SEEK_WR;
                    end else if (startRd) begin
                        mtState_q <= bpc_pkg::MT_SEEK_RD;
                    end else if (startCopy) begin
                        mtState_q <= bpc_pkg::MT_COPY;
                    end
                end
                bpc_pkg::MT_SEEK_WR: begin
                    if (msgTrackIn[8]) begin
                        mtState_q <= bpc_pkg::MT_PUT_WR;
                    end
                end
                bpc_pkg::MT_SEEK_RD: begin
                    if (msgTrackIn[8]) begin
                        mtState_q <= bpc_pkg::MT_GET_RD;
                    end
                end
                bpc_pkg::MT_PUT_WR: mtState_q <= bpc_pkg::MT_IDLE;
                bpc_pkg::MT_GET_RD: mtState_q <= bpc_pkg::MT_IDLE;
                bpc_pkg::MT_COPY: begin
                    if (originPulse) begin
                        mtState_q <= bpc_pkg::MT_IDLE;
                    end
                end
                default: mtState_q <= bpc_pkg::MT_IDLE;
            endcase
        end
    end

    // Old marker dropped
    always_ff @(posedge clk) begin
        if (!nrst) begin
            msgTrackOut  <= 9'h000;
            msgTrackWrEn <= 1'b0;
        end else begin
            msgTrackWrEn <= 1'b0;
            if (spacer) begin
                case (mtState_q)
                    bpc_pkg::MT_SEEK_WR, bpc_pkg::MT_SEEK_RD: begin
                        if (msgTrackIn[8]) begin
                            msgTrackOut  <= {1'b0, msgTrackIn[7:0]};
                            msgTrackWrEn <= 1'b1;
                        end
                    end
                    bpc_pkg::MT_PUT_WR: begin
                        msgTrackOut  <= {1'b1, msgBuf_q.data};
                        msgTrackWrEn <= 1'b1;
                    end
                    bpc_pkg::MT_GET_RD: begin
                        msgTrackOut  <= {1'b1, msgTrackIn[7:0]};
                        msgTrackWrEn <= 1'b1;
                    end
                    default: msgTrackWrEn <= 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            msgBuf_q <= `BPC_RST_WORD;
        end else if (spacer && mtState_q == bpc_pkg::MT_GET_RD) begin
            msgBuf_q <= {~^msgTrackIn[7:0], msgTrackIn[7:0]};
        end else if (isStore && opd == `BPC_OPD_MSGBUF) begin
            msgBuf_q <= {~^storeVal, storeVal};
        end
    end

    // Copy stops at origin
    always_ff @(posedge clk) begin
        if (!nrst) begin
            copyData  <= `BPC_RST_WORD;
            copyDest  <= `BPC_MADDR_CPU;
            copyValid <= 1'b0;
        end else begin
            copyValid <= 1'b0;
            if (startCopy && mtState_q == bpc_pkg::MT_IDLE) begin
                copyDest <= opd[1:0];
            end
            if (spacer && mtState_q == bpc_pkg::MT_COPY && !originPulse) begin
                copyData  <= {~^msgTrackIn[7:0], msgTrackIn[7:0]};
                copyValid <= 1'b1;
            end
        end
    end

    // ----------
    // Registered outputs
    // ----------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ioData    <= `BPC_RST_WORD;
            statusOne <= `BPC_RST_BYTE;
            statusTwo <= `BPC_RST_BYTE;
            accOut    <= `BPC_RST_BYTE;
            halted    <= 1'b0;
        end else begin
            ioData    <= ioReg_q;
            statusOne <= stat1_q;
            statusTwo <= stat2_q;
            accOut    <= acc_q;
            halted    <= halt_q;
        end
    end

endmodule

`default_nettype wire

// *** test/bpc_core_properties.sv ***
// Core port assertions
`timescale 1ns/1ns
`default_nettype none
module bpc_core_checker (
    input wire logic               clk,
    input wire logic               nrst,
    input wire logic               spacerTime,
    input wire logic               msgTrackWrEn,
    input wire logic [8:0]         msgTrackOut,
    input wire logic [7:0]         statusOne,
    input wire logic [7:0]         statusTwo,
    input wire logic [7:0]         accOut,
    input wire logic               scratchWrEn,
    input wire bpc_pkg::bpc_word_s scratchWrData,
    input wire logic               copyValid,
    input wire bpc_pkg::bpc_word_s copyData,
    input wire bpc_pkg::bpc_word_s cpuWord,
    input wire logic               cpuWordValid,
    input wire logic               cpuAccess,
    input wire logic               cpuXferDone,
    input wire bpc_pkg::bpc_word_s inHolder,
    input wire logic               charArrive,
    input wire logic               outHolderEmpty
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence markerClear;
        msgTrackWrEn && !msgTrackOut[8];
    endsequence
    sequence markerSet;
        !msgTrackWrEn[*8] ##1 (msgTrackWrEn && msgTrackOut[8]);
    endsequence
    AST_SPACER_PERIOD: assert property (spacerTime |=> !spacerTime[*8] ##1 spacerTime)
        else $error("spacer gap");
    AST_MARKER_MOVE: assert property (markerClear |=> markerSet)
        else $error("marker move");
    AST_WRITE_SLOT: assert property (msgTrackWrEn |-> $past(spacerTime) || $past(spacerTime, 2))
        else $error("write slot");
    AST_BUSY_HW: assert property (markerClear |-> statusTwo[0])
        else $error("busy low");
    AST_SCRATCH_PAR: assert property (scratchWrEn |-> ^scratchWrData)
        else $error("scratch par");
    AST_COPY_PAR: assert property (copyValid |-> ^copyData)
        else $error("copy par");
    AST_ACC_TIMING: assert property (!$stable(accOut) |-> $past(spacerTime, 2))
        else $error("acc timing");
    AST_OUT_SET: assert property ($rose(statusOne[1]) |-> $past(spacerTime, 2))
        else $error("out set");
    AST_ACCESS: assert property ($rose(cpuAccess) |-> ##[1:10] statusOne[3])
        else $error("access");
    AST_CHAR_WAIT: assert property ($rose(charArrive) |-> ##[1:10] statusOne[0])
        else $error("char wait");
    AST_IF_ERR: assert property ($rose(charArrive) && !(^inHolder) |-> ##[1:10] statusOne[5])
        else $error("if err");
    AST_OUT_CLR: assert property ($rose(outHolderEmpty) |-> ##[1:10] !statusOne[1])
        else $error("out clear");
    AST_AVAIL_CLR: assert property ($rose(cpuXferDone) |-> ##[1:10] !statusOne[2])
        else $error("avail clear");
    AST_CPU_PAR: assert property (cpuWordValid && !(^cpuWord) |-> ##[1:3] statusOne[4])
        else $error("int err");
endmodule
bind bpc_core bpc_core_checker chk_u (.clk, .nrst, .spacerTime, .msgTrackWrEn, .msgTrackOut,
    .statusOne, .statusTwo, .accOut, .scratchWrEn, .scratchWrData, .copyValid, .copyData,
    .cpuWord, .cpuWordValid, .cpuAccess, .cpuXferDone, .inHolder, .charArrive, .outHolderEmpty);
`default_nettype wire

// *** test/bpc_far_model.sv ***
// Far-side model
`timescale 1ns/1ns
`default_nettype none
module bpc_far_model (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic         spacerTime,
    input  wire logic         msgTrackWrEn,
    input  wire logic [8:0]   msgTrackOut,
    output logic [8:0]        msgTrackIn,
    output logic              originPulse,
    output bpc_pkg::bpc_word_s cpuWord,
    output logic              cpuWordValid,
    output logic              cpuAccess,
    output logic              cpuXferDone,
    output bpc_pkg::bpc_word_s inHolder,
    output logic              charArrive,
    output logic              outHolderEmpty
);
    logic [8:0] mt [8];
    logic [2:0] ptr;
    // Short track; marker starts on word 2
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ptr <= 3'h0;
            for (int i = 0; i < 8; i++) mt[i] <= {i == 2, 8'(i * 17)};
        end else begin
            if (spacerTime) ptr <= ptr + 3'h1;
            if (msgTrackWrEn) mt[ptr - 3'h1] <= msgTrackOut;
        end
    end
    assign msgTrackIn = mt[ptr];
    assign originPulse = spacerTime && ptr == 3'h0;
    initial begin
        {cpuWord, cpuWordValid, cpuAccess, cpuXferDone} = 12'h200;
        {inHolder, charArrive, outHolderEmpty} = 11'h400;
    end
    // Released holder shows the inverse
    task automatic char_in(input bpc_pkg::bpc_word_s w);
        inHolder <= w;
        charArrive <= 1'b1;
        repeat (8) @(posedge clk);
        charArrive <= 1'b0;
        inHolder <= ~w;
        repeat (8) @(posedge clk);
    endtask
    task automatic line_pulse(input logic xfer);
        if (xfer) cpuXferDone <= 1'b1;
        else outHolderEmpty <= 1'b1;
        repeat (8) @(posedge clk);
        {cpuXferDone, outHolderEmpty} <= 2'h0;
        repeat (8) @(posedge clk);
    endtask
    task automatic cpu_send(input bpc_pkg::bpc_word_s w, input logic acc);
        cpuWord <= w;
        cpuWordValid <= 1'b1;
        cpuAccess <= acc;
        @(posedge clk);
        cpuWordValid <= 1'b0;
        cpuWord <= ~w;
        repeat (12) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// *** test/bpc_core_test.sv ***
// Core testbench
`timescale 1ns/1ns
`default_nettype none
module bpc_core_test;
    logic               clk = 1'b0;
    logic               nrst = 1'b0;
    bpc_pkg::bpc_word_s progWord = 9'h100, constWord = 9'h100, scratchWord = 9'h100;
    logic [7:0]         jumpWord = 8'h00;
    logic [8:0]         msgTrackIn, msgTrackOut;
    bpc_pkg::bpc_word_s cpuWord, inHolder, scratchWrData, copyData, ioData;
    logic               originPulse, cpuWordValid, cpuAccess, cpuXferDone, charArrive;
    logic               outHolderEmpty, spacerTime, scratchWrEn, msgTrackWrEn, copyValid, halted;
    logic [1:0]         copyDest;
    logic [7:0]         statusOne, statusTwo, accOut;
    int                 mismatches = 0, comparisons = 0;
    bpc_core dut_u (.clk, .nrst, .progWord, .constWord, .scratchWord, .jumpWord, .msgTrackIn,
        .originPulse, .cpuWord, .cpuWordValid, .cpuAccess, .cpuXferDone, .inHolder, .charArrive,
        .outHolderEmpty, .spacerTime, .scratchWrData, .scratchWrEn, .msgTrackOut, .msgTrackWrEn,
        .copyData, .copyDest, .copyValid, .ioData, .statusOne, .statusTwo, .accOut, .halted);
    bpc_far_model far_u (.clk, .nrst, .spacerTime, .msgTrackWrEn, .msgTrackOut, .msgTrackIn,
        .originPulse, .cpuWord, .cpuWordValid, .cpuAccess, .cpuXferDone, .inHolder, .charArrive,
        .outHolderEmpty);
    always #50 clk = ~clk;
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %0t %h %h", $time, seen, exp);
        end
    endtask
    function automatic bpc_pkg::bpc_word_s pw(input logic [7:0] d);
        return {~^d, d};
    endfunction
    task automatic next_s;
        do @(posedge clk); while (spacerTime !== 1'b1);
    endtask
    // Executes two words after fetch
    task automatic op(input bpc_pkg::bpc_op_e o, input logic [3:0] d, input logic [7:0] cw = 8'h00,
                      sw = 8'h00, jw = 8'h00, input logic flip = 1'b0);
        next_s();
        progWord <= {~^{o, d} ^ flip, o, d};
        next_s();
        progWord <= 9'h100;
        next_s();
        {constWord, scratchWord, jumpWord} <= {pw(cw), pw(sw), jw};
        next_s();
        @(posedge clk);
        @(negedge clk);
    endtask
    task automatic wait_idle;
        @(negedge clk);
        chk(statusTwo[0], 1'b1);
        for (int n = 0; n < 400 && statusTwo[0] !== 1'b0; n++) @(negedge clk);
        chk(statusTwo[0], 1'b0);
    endtask
    task automatic test_alu;
        op(bpc_pkg::OP_OR, 4'h3, 8'h4B);
        chk(accOut, 8'h4B);
        op(bpc_pkg::OP_OR, 4'h1, 8'h00, 8'hCC);
        chk(accOut, 8'hCF);
        op(bpc_pkg::OP_AND, 4'h1, 8'h4B, 8'hCC);
        chk(accOut, 8'h48);
        op(bpc_pkg::OP_ADD, 4'h1, 8'h00, 8'hF0);
        chk(accOut, 8'h38);
        op(bpc_pkg::OP_SUB, 4'h1, 8'h00, 8'h40);
        chk(accOut, 8'hF8);
    endtask
    task automatic test_flags;
        op(bpc_pkg::OP_NOP, 4'h0, 8'h00, 8'h00, 8'h00, 1'b1);
        chk(statusOne, 8'h10);
        op(bpc_pkg::OP_AND, 4'h3, 8'h00);
        op(bpc_pkg::OP_STORE, 4'h0, 8'h10);
        chk(statusOne, 8'h00);
        op(bpc_pkg::OP_OR, 4'h3, 8'h06);
        op(bpc_pkg::OP_STORE, 4'h0, 8'h06);
        chk(statusOne, 8'h06);
        far_u.line_pulse(1'b0);
        chk(statusOne, 8'h04);
        far_u.line_pulse(1'b1);
        chk(statusOne, 8'h00);
        far_u.char_in(pw(8'h41));
        chk(ioData, pw(8'h41));
        far_u.char_in(pw(8'h41) ^ 9'h100);
        chk(statusOne, 8'h21);
        far_u.cpu_send(pw(8'h3C) ^ 9'h100, 1'b1);
        chk(statusOne, 8'h39);
    endtask
    task automatic test_skip;
        op(bpc_pkg::OP_CMP, 4'h3, 8'h06, 8'h00, 8'h04);
        op(bpc_pkg::OP_OR, 4'h3, 8'h01);
        chk(accOut, 8'h06);
        op(bpc_pkg::OP_OR, 4'h3, 8'h01);
        chk(accOut, 8'h07);
        op(bpc_pkg::OP_CMP, 4'h3, 8'h00, 8'h00, 8'h04);
        op(bpc_pkg::OP_OR, 4'h3, 8'h08);
        chk(accOut, 8'h0F);
    endtask
    task automatic test_msg;
        op(bpc_pkg::OP_STORE, 4'h2, 8'hFF);
        op(bpc_pkg::OP_STORE, 4'h1, 8'hFF);
        chk(scratchWrData, pw(8'h0F));
        op(bpc_pkg::OP_WORD_MT, 4'h0);
        wait_idle();
        chk(far_u.mt[3], 9'h10F);
        chk(far_u.mt[2][8], 1'b0);
        op(bpc_pkg::OP_WORD_MT, 4'h1);
        wait_idle();
        chk(far_u.mt[4], 9'h144);
        op(bpc_pkg::OP_AND, 4'h3, 8'h00);
        op(bpc_pkg::OP_OR, 4'h2);
        chk(accOut, 8'h44);
        op(bpc_pkg::OP_FROM_MT, 4'h1);
        wait_idle();
        chk(copyDest, 2'h1);
        chk(copyData, 9'h177);
        op(bpc_pkg::OP_HALT, 4'h0);
        chk(halted, 1'b1);
    endtask
    task automatic stop_test;
        if (mismatches == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk(ioData, 9'h100);
        test_alu();
        test_flags();
        test_skip();
        test_msg();
        stop_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
